//--- rla_rx_chain.sv
// Receive descriptor walker: frame spreading, end marking, discard and skip
`timescale 1ns/10ps
`default_nettype none
module rla_rx_chain
	import rla_pkg::*;
#(
	parameter int IDX_W    = rla_pkg::RLA_IDX_W,
	parameter int SIZE_W   = rla_pkg::RLA_SIZE_W,
	parameter int RING_LEN = rla_pkg::RLA_RING_LEN
) (
	input  wire logic                          clock,
	input  wire logic                          rst,
	input  wire logic                          lookahead_chain_enable,
	output logic                               desc_rd_req,
	output logic      [IDX_W-1:0]              desc_rd_idx,
	input  wire logic                          desc_rd_ack,
	input  wire logic                          desc_own,
	input  wire logic                          desc_frame_begin_flag,
	input  wire logic [SIZE_W-1:0]             desc_size,
	output logic                               desc_wr_req,
	output logic      [IDX_W-1:0]              desc_wr_idx,
	output logic                               desc_wr_own,
	output logic                               desc_wr_frame_begin_flag,
	output logic                               desc_wr_frame_end_flag,
	output logic                               desc_wr_fault,
	input  wire logic                          desc_wr_ack,
	input  wire logic                          rx_valid,
	input  wire logic [rla_pkg::RLA_DATA_W-1:0] rx_data,
	input  wire logic                          rx_last,
	input  wire logic                          rx_err,
	output logic                               rx_ready,
	output logic                               buf_valid,
	output logic      [IDX_W-1:0]              buf_idx,
	output logic      [SIZE_W-1:0]             buf_offset,
	output logic      [rla_pkg::RLA_DATA_W-1:0] buf_data,
	output logic                               frame_done,
	output logic      [IDX_W-1:0]              cur_idx
);
	import rla_pkg::*;

	localparam logic [SIZE_W-1:0] ONE = SIZE_W'(1);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	rla_state_t        state, next_state, after, next_after;
	logic [IDX_W-1:0]  succ, next_succ, next_cur;
	logic [SIZE_W-1:0] remain, next_remain, next_offset;
	logic              cur_begin, next_cur_begin, frame_end_pending, next_frame_end_pending;
	logic [IDX_W-1:0]  next_wr_idx;
	logic              next_wr_own, next_wr_begin, next_wr_end, next_wr_fault;
	logic              next_rx_ready;

	wire take      = rx_valid && rx_ready;
	wire rd_done   = desc_rd_req && desc_rd_ack;
	wire wr_done   = desc_wr_req && desc_wr_ack;
	wire may_start = desc_own && (desc_frame_begin_flag || !lookahead_chain_enable);
	wire is_orphan = lookahead_chain_enable && !desc_frame_begin_flag;
	// Chaining never steals a new group's start, even with chaining off
	wire can_chain = desc_own && !desc_frame_begin_flag;

	rla_ring_step #(.IDX_W(IDX_W), .RING_LEN(RING_LEN)) u_step (
		.idx  (next_cur),
		.succ (next_succ)
	);

	// ------------------------------------------------------------
	// Next-state decode
	// ------------------------------------------------------------
	always_comb
	begin
		next_state             = state;
		next_after             = after;
		next_cur               = cur_idx;
		next_remain            = remain;
		next_offset            = buf_offset;
		next_cur_begin         = cur_begin;
		next_frame_end_pending = frame_end_pending;
		next_wr_idx            = desc_wr_idx;
		next_wr_own            = desc_wr_own;
		next_wr_begin          = desc_wr_frame_begin_flag;
		next_wr_end            = desc_wr_frame_end_flag;
		next_wr_fault          = desc_wr_fault;
		unique case (state)
			RLA_S_READ:
				if (rd_done)
				begin
					if (may_start)
					begin
						// Start here; the descriptor stays untouched until data lands
						next_state     = RLA_S_FILL;
						next_remain    = desc_size;
						next_offset    = '0;
						next_cur_begin = desc_frame_begin_flag;
					end
					else if (desc_own && is_orphan)
					begin
						// Discard writes all flags zero
						next_wr_idx            = cur_idx;
						next_wr_own            = RLA_FLAG_CLR;
						next_wr_begin          = RLA_FLAG_CLR;
						next_wr_end            = RLA_FLAG_CLR;
						next_wr_fault          = RLA_FLAG_CLR;
						next_frame_end_pending = RLA_FLAG_CLR;
						next_state             = RLA_S_WR;
						next_after             = RLA_S_READ;
						next_cur               = succ;
					end
					else if (is_orphan)
					begin
						// Unowned, no write: end flag left as it was
						next_cur = succ;
					end
				end
			RLA_S_FILL:
				if (take)
				begin
					next_remain = remain - ONE;
					next_offset = buf_offset + ONE;
					if (rx_last)
					begin
						// Frame ends in this buffer
						next_wr_idx            = cur_idx;
						next_wr_own            = RLA_FLAG_CLR;
						next_wr_begin          = cur_begin;
						next_wr_end            = !rx_err;
						next_wr_fault          = rx_err;
						next_frame_end_pending = RLA_FLAG_SET;
						next_state             = RLA_S_WR;
						next_after             = RLA_S_READ;
						next_cur               = succ;
					end
					else if (remain == ONE)
						next_state = RLA_S_LOOK;
				end
			RLA_S_LOOK:
				if (rd_done)
				begin
					next_wr_idx            = cur_idx;
					next_wr_own            = RLA_FLAG_CLR;
					next_wr_begin          = cur_begin;
					next_wr_end            = RLA_FLAG_CLR;
					next_frame_end_pending = RLA_FLAG_SET;
					next_state             = RLA_S_WR;
					next_cur               = succ;
					if (can_chain)
					begin
						// Spill into the owned successor
						next_wr_fault          = RLA_FLAG_CLR;
						next_frame_end_pending = RLA_FLAG_CLR;
						next_after             = RLA_S_FILL;
						next_remain            = desc_size;
						next_offset            = '0;
						next_cur_begin         = RLA_FLAG_CLR;
					end
					else
					begin
						// No buffer to chain into: close with fault, drop the rest
						next_wr_fault = RLA_FLAG_SET;
						next_after    = RLA_S_DROP;
					end
				end
			RLA_S_WR:
				if (wr_done)
					next_state = after;
			RLA_S_DROP:
				if (take && rx_last)
					next_state = RLA_S_READ;
		endcase
	end

	always_comb
	begin
		next_rx_ready = 1'b0;
		if (next_state == RLA_S_DROP)
			next_rx_ready = 1'b1;
		else if (next_state == RLA_S_FILL)
			next_rx_ready = (next_remain != '0);
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			state                    <= RLA_S_READ;
			after                    <= RLA_S_READ;
			cur_idx                  <= IDX_W'(RLA_RESET_IDX);
			succ                     <= IDX_W'(RLA_RESET_SUCC);
			remain                   <= '0;
			buf_offset               <= '0;
			cur_begin                <= RLA_FLAG_CLR;
			frame_end_pending        <= RLA_FLAG_CLR;
			desc_rd_req              <= 1'b0;
			desc_rd_idx              <= '0;
			desc_wr_req              <= 1'b0;
			desc_wr_idx              <= '0;
			desc_wr_own              <= RLA_FLAG_CLR;
			desc_wr_frame_begin_flag <= RLA_FLAG_CLR;
			desc_wr_frame_end_flag   <= RLA_FLAG_CLR;
			desc_wr_fault            <= RLA_FLAG_CLR;
			rx_ready                 <= 1'b0;
			buf_valid                <= 1'b0;
			buf_idx                  <= '0;
			buf_data                 <= '0;
			frame_done               <= 1'b0;
		end
		else
		begin
			state                    <= next_state;
			after                    <= next_after;
			cur_idx                  <= next_cur;
			succ                     <= next_succ;
			remain                   <= next_remain;
			buf_offset               <= next_offset;
			cur_begin                <= next_cur_begin;
			frame_end_pending        <= next_frame_end_pending;
			// Look-ahead reads the successor while the current buffer is still held
			desc_rd_req              <= (next_state == RLA_S_READ) || (next_state == RLA_S_LOOK);
			desc_rd_idx              <= (next_state == RLA_S_LOOK) ? next_succ : next_cur;
			desc_wr_req              <= (next_state == RLA_S_WR);
			desc_wr_idx              <= next_wr_idx;
			desc_wr_own              <= next_wr_own;
			desc_wr_frame_begin_flag <= next_wr_begin;
			desc_wr_frame_end_flag   <= next_wr_end;
			desc_wr_fault            <= next_wr_fault;
			rx_ready                 <= next_rx_ready;
			buf_valid                <= take && (state == RLA_S_FILL);
			buf_idx                  <= cur_idx;
			buf_data                 <= rx_data;
			frame_done               <= wr_done && frame_end_pending;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	start_here_a: assert property (@(posedge clock) disable iff (rst)
		state == RLA_S_READ && rd_done && lookahead_chain_enable && !(desc_own && desc_frame_begin_flag)
		|=> state != RLA_S_FILL)
		else $error("frame started without holder and begin");
	keep_current_a: assert property (@(posedge clock) disable iff (rst)
		state == RLA_S_READ && rd_done && desc_own && desc_frame_begin_flag
		|=> state == RLA_S_FILL && !desc_wr_req && cur_idx == $past(cur_idx))
		else $error("start descriptor touched");
	orphan_discard_a: assert property (@(posedge clock) disable iff (rst)
		state == RLA_S_READ && rd_done && lookahead_chain_enable && desc_own && !desc_frame_begin_flag
		|=> desc_wr_req && !desc_wr_own && !desc_wr_frame_end_flag && !desc_wr_frame_begin_flag
		&& desc_wr_idx == $past(cur_idx))
		else $error("owned orphan not discarded with zeros");
	skip_unowned_a: assert property (@(posedge clock) disable iff (rst)
		state == RLA_S_READ && rd_done && lookahead_chain_enable && !desc_own && !desc_frame_begin_flag
		|=> !desc_wr_req && desc_rd_req && desc_rd_idx == $past(succ))
		else $error("unowned entry not skipped");
	frame_end_a: assert property (@(posedge clock) disable iff (rst)
		state == RLA_S_FILL && take && rx_last
		|=> desc_wr_req && desc_wr_frame_end_flag == !$past(rx_err) && desc_wr_fault == $past(rx_err)
		&& !desc_wr_own && desc_wr_idx == $past(cur_idx))
		else $error("frame end not marked in its buffer");
	spill_look_a: assert property (@(posedge clock) disable iff (rst)
		state == RLA_S_FILL && take && !rx_last && remain == ONE
		|=> state == RLA_S_LOOK && desc_rd_req && desc_rd_idx == $past(succ) && !rx_ready)
		else $error("full buffer did not look ahead");
	chain_mid_a: assert property (@(posedge clock) disable iff (rst)
		state == RLA_S_LOOK && rd_done && can_chain
		|=> desc_wr_req && !desc_wr_frame_end_flag && !desc_wr_own && !desc_wr_fault
		&& desc_wr_frame_begin_flag == $past(cur_begin) && desc_wr_idx == $past(cur_idx))
		else $error("middle buffer returned wrongly");
	no_chain_unowned_a: assert property (@(posedge clock) disable iff (rst)
		state == RLA_S_LOOK && rd_done && !desc_own
		|=> desc_wr_fault ##1 (state != RLA_S_FILL) [*2])
		else $error("chained into an unowned buffer");
	write_hold_a: assert property (@(posedge clock) disable iff (rst)
		desc_wr_req && !desc_wr_ack |=> desc_wr_req && $stable(desc_wr_idx)
		&& $stable(desc_wr_frame_end_flag))
		else $error("descriptor write dropped before ack");
	ready_scope_a: assert property (@(posedge clock) disable iff (rst)
		rx_ready |-> (state == RLA_S_FILL && remain != '0) || state == RLA_S_DROP)
		else $error("bytes accepted with no buffer");
endmodule : rla_rx_chain
`default_nettype wire

//--- rla_pkg.sv
// Shared constants and types for the receive look-ahead descriptor chain
`default_nettype none
package rla_pkg;
	// ------------------------------------------------------------
	// Sizes and reset values
	// ------------------------------------------------------------
	localparam int         RLA_IDX_W      = 4;
	localparam int         RLA_SIZE_W     = 16;
	localparam int         RLA_RING_LEN   = 9;
	localparam int         RLA_DATA_W     = 8;
	localparam logic [3:0] RLA_RESET_IDX  = 4'h0;
	localparam logic [3:0] RLA_RESET_SUCC = 4'h1;
	localparam logic       RLA_FLAG_CLR   = 1'b0;
	localparam logic       RLA_FLAG_SET   = 1'b1;

	// ------------------------------------------------------------
	// Controller states
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		RLA_S_READ,
		RLA_S_FILL,
		RLA_S_LOOK,
		RLA_S_WR,
		RLA_S_DROP
	} rla_state_t;
endpackage : rla_pkg
`default_nettype wire

//--- rla_ring_step.sv
// Successor of a descriptor index around the receive ring
`timescale 1ns/10ps
`default_nettype none
module rla_ring_step #(
	parameter int IDX_W    = rla_pkg::RLA_IDX_W,
	parameter int RING_LEN = rla_pkg::RLA_RING_LEN
) (
	input  wire logic [IDX_W-1:0] idx,
	output logic      [IDX_W-1:0] succ
);
	import rla_pkg::*;

	localparam logic [IDX_W-1:0] LAST = IDX_W'(RING_LEN - 1);
	localparam logic [IDX_W-1:0] ONE  = IDX_W'(1);

	assign succ = (idx == LAST) ? '0 : idx + ONE;
endmodule : rla_ring_step
`default_nettype wire

//--- rla_host_model.sv
// Host-side descriptor ring model answering the chain's reads and writes
`timescale 1ns/10ps
`default_nettype none
module rla_host_model (
	input  wire logic                           clock,
	input  wire logic                           rst,
	input  wire logic                           rd_req,
	input  wire logic [rla_pkg::RLA_IDX_W-1:0]  rd_idx,
	output logic                                rd_ack,
	output logic                                rd_own,
	output logic                                rd_begin,
	output logic      [rla_pkg::RLA_SIZE_W-1:0] rd_size,
	input  wire logic                           wr_req,
	input  wire logic [rla_pkg::RLA_IDX_W-1:0]  wr_idx,
	input  wire logic                           wr_own,
	input  wire logic                           wr_begin,
	input  wire logic                           wr_end,
	input  wire logic                           wr_fault,
	output logic                                wr_ack
);
	import rla_pkg::*;
	logic                  own   [0:15];
	logic                  beg   [0:15];
	logic                  endf  [0:15];
	logic                  flt   [0:15];
	logic [RLA_SIZE_W-1:0] size  [0:15];
	int unsigned           delay = 0;
	int unsigned           rd_wait;
	int unsigned           wr_wait;
	logic                  junk  = 1'b0;
	// ------------------------------------------------------------
	// Answers
	// ------------------------------------------------------------
	// Outside an answer the read lines toggle, so a late sample never looks valid
	always @(posedge clock)
	begin
		junk <= ~junk;
		rd_ack <= 1'b0;
		wr_ack <= 1'b0;
		rd_own <= junk;
		rd_begin <= ~junk;
		rd_size <= {RLA_SIZE_W{junk}};
		if (rst)
		begin
			rd_wait <= 0;
			wr_wait <= 0;
		end
		else
		begin
			if (rd_req && !rd_ack)
			begin
				rd_wait <= (rd_wait == delay) ? 0 : rd_wait + 1;
				if (rd_wait == delay)
				begin
					rd_ack <= 1'b1;
					rd_own <= own[rd_idx];
					rd_begin <= beg[rd_idx];
					rd_size <= size[rd_idx];
				end
			end
			if (wr_req && !wr_ack)
			begin
				wr_wait <= (wr_wait == delay) ? 0 : wr_wait + 1;
				if (wr_wait == delay)
				begin
					wr_ack <= 1'b1;
					{own[wr_idx], beg[wr_idx], endf[wr_idx], flt[wr_idx]} <=
						{wr_own, wr_begin, wr_end, wr_fault};
				end
			end
		end
	end
endmodule : rla_host_model
`default_nettype wire

//--- tb_rla_rx_chain.sv
// Self-checking bench for the receive look-ahead descriptor chain
`timescale 1ns/10ps
`default_nettype none
module tb_rla_rx_chain;
	import rla_pkg::*;
	logic                  clock = 1'b0;
	logic                  rst = 1'b1;
	logic                  rx_valid = 1'b0, rx_last = 1'b0, rx_err = 1'b0;
	logic [RLA_DATA_W-1:0] rx_data = 8'h00;
	logic                  chain_en = 1'b1;
	logic [RLA_DATA_W-1:0] b_data;
	logic                  rd_req, rd_ack, d_own, d_beg, wr_req, wr_ack;
	logic                  w_own, w_beg, w_end, w_flt, rx_ready, b_valid, done;
	logic [RLA_IDX_W-1:0]  rd_idx, wr_idx, b_idx, cur_idx;
	logic [RLA_SIZE_W-1:0] d_size, b_off;
	int                    miscompares = 0, n_compared = 0, cycles = 0, n_done = 0, n_placed = 0;
	int                    cnt [0:15];
	always #5 clock = ~clock;
	rla_rx_chain u_dut (.clock(clock), .rst(rst), .lookahead_chain_enable(chain_en),
		.desc_rd_req(rd_req), .desc_rd_idx(rd_idx), .desc_rd_ack(rd_ack), .desc_own(d_own),
		.desc_frame_begin_flag(d_beg), .desc_size(d_size), .desc_wr_req(wr_req),
		.desc_wr_idx(wr_idx), .desc_wr_own(w_own), .desc_wr_frame_begin_flag(w_beg),
		.desc_wr_frame_end_flag(w_end), .desc_wr_fault(w_flt), .desc_wr_ack(wr_ack),
		.rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last), .rx_err(rx_err),
		.rx_ready(rx_ready), .buf_valid(b_valid), .buf_idx(b_idx), .buf_offset(b_off),
		.buf_data(b_data), .frame_done(done), .cur_idx(cur_idx));
	rla_host_model u_host (.clock(clock), .rst(rst), .rd_req(rd_req), .rd_idx(rd_idx),
		.rd_ack(rd_ack), .rd_own(d_own), .rd_begin(d_beg), .rd_size(d_size),
		.wr_req(wr_req), .wr_idx(wr_idx), .wr_own(w_own), .wr_begin(w_beg), .wr_end(w_end),
		.wr_fault(w_flt), .wr_ack(wr_ack));
	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic end_of_test();
		$display("compared %0d, miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_of_test
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	// Holder, begin, and end-or-fault of one descriptor
	task automatic desc(input int i, input logic [2:0] exp);
		check({13'h0, u_host.own[i], u_host.beg[i], u_host.endf[i] | u_host.flt[i]}, {13'h0, exp});
	endtask : desc
	task automatic arm(input int i, input logic [2:0] f, input logic [15:0] sz);
		{u_host.own[i], u_host.beg[i], u_host.endf[i]} = f;
		u_host.flt[i] = 1'b0;
		u_host.size[i] = sz;
	endtask : arm
	task automatic send(input int n, input logic err);
		int k;
		cnt = '{default: 0};
		n_placed = 0;
		k = n_done;
		for (int i = 0; i < n; i++)
		begin
			rx_valid = 1'b1;
			rx_data = i[7:0];
			rx_last = (i == n - 1);
			rx_err = err & rx_last;
			while (rx_ready !== 1'b1)
				@(negedge clock);
			@(negedge clock);
		end
		rx_valid = 1'b0;
		rx_last = 1'b0;
		rx_err = 1'b0;
		// Frames are delimited by completions; stale end flags are never parsed
		while (n_done == k)
			@(negedge clock);
		// Let the start search settle before the ring is inspected
		repeat (40) @(negedge clock);
	endtask : send
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic s_spill();
		send(1060, 1'b0);
		check(16'(cnt[0]), 16'd800);
		check(16'(cnt[1]), 16'd200);
		check(16'(cnt[2]), 16'd60);
		desc(0, 3'b010);
		desc(1, 3'b000);
		desc(2, 3'b001);
		desc(3, 3'b110);
		check({12'h0, cur_idx}, 16'h3);
		arm(0, 3'b110, 16'd800);
		arm(1, 3'b101, 16'd200);
		arm(2, 3'b001, 16'd200);
	endtask : s_spill
	task automatic s_two();
		send(900, 1'b0);
		check(16'(cnt[4]), 16'd100);
		check(16'(cnt[5]), 16'd0);
		desc(3, 3'b010);
		desc(4, 3'b001);
		desc(5, 3'b001);
		check({12'h0, cur_idx}, 16'h6);
	endtask : s_two
	// Slow host, faulty frame, owned orphan in descriptor 8 discarded
	task automatic s_late();
		u_host.delay = 3;
		send(900, 1'b1);
		desc(6, 3'b010);
		desc(7, 3'b001);
		desc(8, 3'b000);
		check({12'h0, cur_idx}, 16'h0);
		u_host.delay = 0;
	endtask : s_late
	task automatic s_one();
		send(100, 1'b0);
		desc(0, 3'b011);
		desc(1, 3'b000);
		desc(2, 3'b001);
		check({12'h0, cur_idx}, 16'h3);
		rx_valid = 1'b1;
		repeat (20) @(negedge clock);
		check({15'h0, rx_ready}, 16'h0);
		rx_valid = 1'b0;
	endtask : s_one
	// Third buffer never handed over: fault in buffer two, rest of the frame dropped
	task automatic s_drop();
		arm(3, 3'b110, 16'd800);
		arm(4, 3'b100, 16'd200);
		arm(5, 3'b000, 16'd200);
		send(1100, 1'b0);
		check(16'(cnt[3]), 16'd800);
		check(16'(cnt[4]), 16'd200);
		check(16'(cnt[5]), 16'd0);
		desc(3, 3'b010);
		desc(4, 3'b001);
		desc(5, 3'b000);
		check({12'h0, cur_idx}, 16'h6);
	endtask : s_drop
	// Chaining off: a held descriptor starts a frame whatever its begin flag
	task automatic s_off();
		chain_en = 1'b0;
		arm(6, 3'b100, 16'd200);
		send(50, 1'b0);
		check(16'(cnt[6]), 16'd50);
		desc(6, 3'b001);
		check({12'h0, cur_idx}, 16'h7);
		chain_en = 1'b1;
		repeat (40) @(negedge clock);
		check({12'h0, cur_idx}, 16'h0);
	endtask : s_off
	// ------------------------------------------------------------
	// Monitor, watchdog and main sequence
	// ------------------------------------------------------------
	always @(posedge clock)
	begin
		cycles++;
		if (done === 1'b1)
			n_done++;
		if (b_valid === 1'b1)
		begin
			check(b_off, 16'(cnt[b_idx] + 1));
			check({8'h0, b_data}, 16'(n_placed % 256));
			cnt[b_idx]++;
			n_placed++;
		end
		if (cycles == 20000)
		begin
			miscompares++;
			end_of_test();
		end
	end
	initial
	begin
		for (int g = 0; g < 9; g += 3)
		begin
			arm(g, 3'b110, 16'd800);
			arm(g + 1, 3'b100, 16'd200);
			arm(g + 2, 3'b001, 16'd200);
		end
		arm(2, 3'b100, 16'd200);
		arm(8, 3'b101, 16'd200);
		repeat (16) @(negedge clock);
		rst = 1'b0;
		s_spill();
		s_two();
		s_late();
		s_one();
		s_drop();
		s_off();
		end_of_test();
	end
endmodule : tb_rla_rx_chain
`default_nettype wire
